// ---- bench/mptr_board.sv ----
// board circuitry model on the seven multipurpose terminals
// assumes: the bench sets what the board drives on each undriven terminal
// ---------------------------------------------------------------------------
// terminal wire resolution
// ---------------------------------------------------------------------------
`timescale 1ns/1ps

module mptr_board (
  // device drive
  input  wire logic [6:0] pin_i,
  input  wire logic [6:0] oe_i,
  // board side levels
  input  wire logic [6:0] level_i,
  // resolved terminal wires
  output logic      [6:0] wire_o
);
  // device drive wins, else the board level shows on the wire
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      wire_o[i] = oe_i[i] ? pin_i[i] : level_i[i];
    end
  end
endmodule

// ---- bench/tb.sv ----
// self-checking bench for the multipurpose terminal router
// assumes: mptr_router and mptr_board compiled, 100 MHz clock
// ---------------------------------------------------------------------------
// stimulus, expectations and verdict
// ---------------------------------------------------------------------------
`timescale 1ns/1ps

module tb;
  import mptr_pkg::*;
  logic        clock_i, rst_n_i, cfg_wr_i, cfg_rd_i, eeprom_load_i;
  logic        latch_pin_i, scl_drive_low_i, clkrun_out_i, clkrun_oe_i;
  logic        serialized_interrupt_out_i, serialized_interrupt_oe_i;
  logic        legacy_dma_request_i, video_port_status_i, card_audio_pwm_i;
  logic        video_port_select_0_i, video_port_select_1_i, pme_i;
  logic        low_power_state_flag_i, activity_led_1_i, activity_led_2_i;
  logic        socket_activity_led_i, wake_event_output_i;
  logic        ring_indicate_output_i, ring_indicate_en_i, hit_s;
  logic        ring_wake_mux_select_i, cfg_hit_o, scl_in_o, pci_lock_o;
  logic        legacy_dma_grant_o, clkrun_in_o, ring_wake_pin_o;
  logic        serialized_interrupt_in_o;
  logic [2:0]  cfg_func_i;
  logic [7:0]  cfg_addr_i;
  logic [3:0]  cfg_be_i;
  logic [31:0] cfg_wdata_i, eeprom_data_i, cfg_rdata_o, rd_s;
  logic [4:0]  general_output_bit_i, general_input_bit_o;
  logic [15:0] irq_i;
  logic [6:0]  multipurpose_pin_i, multipurpose_pin_o, board_level;
  logic [6:0]  multipurpose_pin_oe_o;
  logic [1:0]  e;
  int          mismatches, samples_checked;

  mptr_router uut (.*);
  mptr_board board (.pin_i(multipurpose_pin_o), .oe_i(multipurpose_pin_oe_o),
                    .level_i(board_level), .wire_o(multipurpose_pin_i));

  // clock
  always #5 clock_i = ~clock_i;

  // compare helpers
  task automatic chk_word(input string n, input logic [31:0] x, g);
    samples_checked++;
    if (g !== x) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic x, g);
    chk_word(n, {31'h0, x}, {31'h0, g});
  endtask

  // one config access; answer sampled in the cycle it stands
  task automatic cfg(input logic w, input logic [2:0] f, input logic [7:0] a,
                     input logic [3:0] b, input logic [31:0] d);
    @(negedge clock_i);
    {cfg_wr_i, cfg_rd_i, cfg_func_i, cfg_addr_i, cfg_be_i} = {w, ~w, f, a, b};
    cfg_wdata_i = d;
    @(negedge clock_i);
    hit_s = cfg_hit_o;
    rd_s = cfg_rdata_o;
    {cfg_wr_i, cfg_rd_i} = 2'b00;
  endtask
  task automatic rd_chk(input logic [2:0] f, input logic [7:0] a,
                        input logic [31:0] x, input logic h);
    cfg(1'b0, f, a, 4'h0, 32'h0);
    chk_word("read data", x, rd_s);
    chk_bit("hit", h, hit_s);
  endtask

  // source pattern p gives each irq line, and each of the 11 sources packed in m, a distinct signature over 4 patterns
  task automatic set_src(input int p);
    logic [10:0] m;
    for (int j = 0; j < 16; j++) begin
      irq_i[j] = 1'((j + 5) >> p);
      if (j < 11) m[j] = 1'((j + 1) >> p);
    end
    {legacy_dma_request_i, video_port_status_i, video_port_select_0_i,
     video_port_select_1_i, card_audio_pwm_i, low_power_state_flag_i,
     activity_led_1_i, activity_led_2_i, socket_activity_led_i,
     wake_event_output_i, ring_indicate_output_i} = m;
    general_output_bit_i = 5'(23 >> p);
    {clkrun_out_i, clkrun_oe_i} = {p[0], p[1]};
    {serialized_interrupt_out_i, serialized_interrupt_oe_i} = ~{p[0], p[1]};
    board_level = 7'(8'h5A >> p);
  endtask

  // expected {oe, value} of terminal t under code c
  function automatic logic [1:0] exp_pin(input int t, input logic [3:0] c);
    logic d;
    logic v;
    d = 1'b1;
    v = irq_i[c];
    case (t)
      0, 1: begin
        d = (c == 4'h1);
        v = general_output_bit_i[t];
      end
      2: case (c)
        4'h0: d = 1'b0;
        4'h1: v = general_output_bit_i[2];
        4'h2: v = legacy_dma_request_i;
        4'h6: v = video_port_status_i;
        4'h7: v = video_port_select_0_i;
        4'h8: v = card_audio_pwm_i;
        4'hB: v = low_power_state_flag_i;
        4'hC: v = ring_indicate_output_i;
        4'hD: v = activity_led_2_i;
        4'hE: v = wake_event_output_i;
        4'hF: v = irq_i[7];
        default: ;
      endcase
      4: case (c)
        4'h0, 4'h2, 4'h3, 4'h7, 4'hB, 4'hF: d = 1'b0;
        4'h1: v = general_output_bit_i[3];
        4'h6: v = video_port_status_i;
        4'h8: v = card_audio_pwm_i;
        4'hC: v = ring_indicate_output_i;
        4'hD: v = socket_activity_led_i;
        4'hE: v = wake_event_output_i;
        default: ;
      endcase
      5: case (c)
        4'h0, 4'h2: d = 1'b0;
        4'h1: v = general_output_bit_i[4];
        4'h6: v = video_port_status_i;
        4'h7: v = video_port_select_1_i;
        4'h8: v = card_audio_pwm_i;
        4'h9: v = low_power_state_flag_i;
        4'hC: v = activity_led_1_i;
        4'hD: v = socket_activity_led_i;
        4'hE: v = wake_event_output_i;
        default: ;
      endcase
      3: if (c == 4'h0) d = 1'b0;
        else if (c == 4'h1) {d, v} = {serialized_interrupt_oe_i,
                                      serialized_interrupt_out_i};
      default: if (c == 4'h0) d = 1'b0;
        else if (c == 4'h1) {d, v} = {clkrun_oe_i, clkrun_out_i};
    endcase
    return {d, v};
  endfunction

  // verdict and end of run
  task automatic stop_test();
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // watchdog
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end

  // main sequence
  initial begin
    {clock_i, rst_n_i, cfg_wr_i, cfg_rd_i, eeprom_load_i} = 5'b0;
    {cfg_func_i, cfg_addr_i, cfg_be_i, cfg_wdata_i} = 47'h0;
    {eeprom_data_i, scl_drive_low_i, pme_i, ring_wake_mux_select_i} = 35'h0;
    {latch_pin_i, ring_indicate_en_i} = 2'b11;
    set_src(3);
    repeat (5) @(negedge clock_i);
    rst_n_i = 1'b1;
    @(negedge clock_i);
    chk_word("oe after reset", 32'h0, {25'h0, multipurpose_pin_oe_o});
    rd_chk(3'h0, 8'h8C, MPTR_ROUTING_RST, 1'b1);
    rd_chk(3'h1, 8'h8C, 32'h0000_1000, 1'b1);
    rd_chk(3'h2, 8'h8C, 32'h0, 1'b0);
    rd_chk(3'h0, 8'h88, 32'h0, 1'b0);
    cfg(1'b1, 3'h0, 8'h8C, 4'hF, 32'hFFFF_FFFF);
    rd_chk(3'h1, 8'h8C, 32'h0FFF_FFFF, 1'b1);
    cfg(1'b1, 3'h0, 8'h8C, 4'h1, 32'h0);
    rd_chk(3'h0, 8'h8C, 32'h0FFF_FF00, 1'b1);
    // eeprom load in the same cycle as a write
    @(negedge clock_i);
    {eeprom_load_i, cfg_wr_i, cfg_func_i, cfg_addr_i, cfg_be_i} =
      {2'b11, 3'h0, 8'h8C, 4'hF};
    {eeprom_data_i, cfg_wdata_i} = {32'hF123_4567, 32'h0};
    @(negedge clock_i);
    {eeprom_load_i, cfg_wr_i} = 2'b00;
    rd_chk(3'h0, 8'h8C, 32'h0123_4567, 1'b1);
    // every code on every terminal under four source patterns
    for (int p = 0; p < 4; p++) begin
      set_src(p);
      for (int c = 0; c < 16; c++) begin
        cfg(1'b1, 3'h1, 8'h8C, 4'hF, {4'h0, {7{4'(c)}}});
        repeat (6) @(negedge clock_i);
        for (int t = 0; t < 7; t++) begin
          e = exp_pin(t, 4'(c));
          chk_bit("pin oe", e[1], multipurpose_pin_oe_o[t]);
          if (e[1]) chk_bit("pin out", e[0], multipurpose_pin_o[t]);
        end
        if (c == 0) chk_word("inputs", {27'h0, multipurpose_pin_i[5:4],
          multipurpose_pin_i[2:0]}, {27'h0, general_input_bit_o});
        if (c == 1) chk_bit("clkrun in", multipurpose_pin_i[6], clkrun_in_o);
        if (c == 1) chk_bit("serirq in", multipurpose_pin_i[3],
                            serialized_interrupt_in_o);
        if (c == 2) chk_bit("grant", multipurpose_pin_i[5], legacy_dma_grant_o);
        if (c == 2) chk_bit("lock", multipurpose_pin_i[4], pci_lock_o);
      end
    end
    // shared ring / wake terminal, all sixteen input combinations
    for (int k = 0; k < 16; k++) begin
      {ring_wake_mux_select_i, ring_indicate_en_i, ring_indicate_output_i,
       pme_i} = 4'(k);
      repeat (3) @(negedge clock_i);
      chk_bit("ring wake", (k[3] || !k[2]) ? k[0] : k[1], ring_wake_pin_o);
    end
    // serial-bus mode takes terminal 4 away from its input code 0
    cfg(1'b1, 3'h0, 8'h8C, 4'hF, 32'h0);
    {latch_pin_i, scl_drive_low_i, board_level[4]} = 3'b011;
    repeat (6) @(negedge clock_i);
    chk_bit("scl oe", 1'b1, multipurpose_pin_oe_o[4]);
    chk_bit("scl out", 1'b0, multipurpose_pin_o[4]);
    chk_bit("scl in", 1'b0, scl_in_o);
    scl_drive_low_i = 1'b0;
    repeat (6) @(negedge clock_i);
    chk_bit("scl oe", 1'b0, multipurpose_pin_oe_o[4]);
    chk_bit("scl in", 1'b1, scl_in_o);
    chk_bit("general_input_bit_3 serial", 1'b0, general_input_bit_o[3]);
    stop_test();
  end
endmodule

// ---- logic/mptr_pin_mux.sv ----
// ---------------------------------------------------------------------------
// multipurpose terminal router: one terminal's output selector
// ---------------------------------------------------------------------------
// assumes: value and enable tables are built by the router top

`timescale 1ns/1ps

module mptr_pin_mux
  import mptr_pkg::*;
(
  // clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  // selection and candidate sources
  input  wire logic [MPTR_FLD_W-1:0] sel_i,
  input  wire logic [MPTR_CODES-1:0] src_val_i,
  input  wire logic [MPTR_CODES-1:0] src_oe_i,
  // override path for a dedicated function
  input  wire logic                  force_en_i,
  input  wire logic                  force_val_i,
  input  wire logic                  force_oe_i,
  // registered terminal drive
  output logic                       pin_o,
  output logic                       pin_oe_o
);

  // terminal drive, released at reset so the terminal is an input
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
    end else if (force_en_i) begin
      pin_o    <= force_val_i;
      pin_oe_o <= force_oe_i;
    end else begin
      pin_o    <= src_val_i[sel_i];
      pin_oe_o <= src_oe_i[sel_i];
    end
  end

endmodule

// ---- logic/mptr_pkg.sv ----
// ---------------------------------------------------------------------------
// multipurpose terminal router: shared constants
// ---------------------------------------------------------------------------
// assumes: imported whole by every router module

package mptr_pkg;

  // terminal count and selector field width
  localparam int MPTR_PINS  = 7;
  localparam int MPTR_FLD_W = 4;
  localparam int MPTR_CODES = 16;

  // configuration space placement of the routing register
  localparam logic [7:0]  MPTR_ROUTING_OFS   = 8'h8C;
  localparam logic [2:0]  MPTR_FUNC_0        = 3'h0;
  localparam logic [2:0]  MPTR_FUNC_1        = 3'h1;
  localparam logic [31:0] MPTR_ROUTING_RST   = 32'h0000_1000;
  localparam logic [31:0] MPTR_ROUTING_WMASK = 32'h0FFF_FFFF;

  // selector codes, some shared by several terminals, some for one terminal only
  localparam logic [3:0] MPTR_SEL_GPI      = 4'h0;
  localparam logic [3:0] MPTR_SEL_RSVD     = 4'h0;
  localparam logic [3:0] MPTR_SEL_GPO      = 4'h1;
  localparam logic [3:0] MPTR_SEL_CLKRUN   = 4'h1;
  localparam logic [3:0] MPTR_SEL_SERIRQ   = 4'h1;
  localparam logic [3:0] MPTR_SEL_DMA      = 4'h2;
  localparam logic [3:0] MPTR_SEL_LOCK     = 4'h2;
  localparam logic [3:0] MPTR_SEL_VSTAT    = 4'h6;
  localparam logic [3:0] MPTR_SEL_VSEL     = 4'h7;
  localparam logic [3:0] MPTR_SEL_AUDIO    = 4'h8;
  localparam logic [3:0] MPTR_SEL_D3_T5    = 4'h9;
  localparam logic [3:0] MPTR_SEL_D3_T2    = 4'hB;
  localparam logic [3:0] MPTR_SEL_RING     = 4'hC;
  localparam logic [3:0] MPTR_SEL_LED1     = 4'hC;
  localparam logic [3:0] MPTR_SEL_SKTLED   = 4'hD;
  localparam logic [3:0] MPTR_SEL_LED2     = 4'hD;
  localparam logic [3:0] MPTR_SEL_WAKE     = 4'hE;
  localparam logic [3:0] MPTR_SEL_IRQ7_T2  = 4'hF;
  localparam int         MPTR_IRQ7         = 7;

  // codes that carry irq line n as code n, per terminal
  localparam logic [15:0] MPTR_IRQ_MASK_T6 = 16'hFFFC;
  localparam logic [15:0] MPTR_IRQ_MASK_T5 = 16'h8C38;
  localparam logic [15:0] MPTR_IRQ_MASK_T4 = 16'h0630;
  localparam logic [15:0] MPTR_IRQ_MASK_T3 = 16'hFFFC;
  localparam logic [15:0] MPTR_IRQ_MASK_T2 = 16'h0638;

endpackage

// ---- logic/mptr_router.sv ----
// ---------------------------------------------------------------------------
// multipurpose terminal router: routing register and terminal selection
// ---------------------------------------------------------------------------
// assumes: configuration cycles arrive decoded as single-cycle strobes on
// the pci clock; terminals are resolved to wires outside from out and oe.
//
// Summary of operation
// - after reset terminals 0, 1, 2, 4 and 5 are general-purpose inputs, terminal 3 carries serialized interrupt, terminal 6 is reserved
// - routing register at 8Ch for functions 0 and 1, resets to 1000h
// - bits 31 to 28 read zero and ignore writes
// - an eeprom load may replace the register contents at initialization
// - terminal 6: reserved default, clkrun, or irq2 to irq15
// - terminal 5: input 4 default, output 4, grant, irqs, video, leds, wake
// - terminal 4: input 3 default, output 3, lock, irqs, ring, leds, wake
// - serial-bus mode forces terminal 4 to carry the serial clock
// - terminal 3: reserved, serialized interrupt default, irq2 to irq15
// - terminal 2: input 2 default, output 2, request, irqs, d3, leds, wake
// - mux bit 0: ring and wake share terminal, ring wins if both on
// - mux bit 1: only wake event reaches the shared terminal
// - terminals 1 and 0 use the same 4-bit selection manner

`timescale 1ns/1ps

module mptr_router
  import mptr_pkg::*;
(
  // clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  // configuration space access
  input  wire logic                 cfg_wr_i,
  input  wire logic                 cfg_rd_i,
  input  wire logic [2:0]           cfg_func_i,
  input  wire logic [7:0]           cfg_addr_i,
  input  wire logic [3:0]           cfg_be_i,
  input  wire logic [31:0]          cfg_wdata_i,
  output logic      [31:0]          cfg_rdata_o,
  output logic                      cfg_hit_o,
  // eeprom default load
  input  wire logic                 eeprom_load_i,
  input  wire logic [31:0]          eeprom_data_i,
  // serial bus mode strap and clock drive
  input  wire logic                 latch_pin_i,
  input  wire logic                 scl_drive_low_i,
  output logic                      scl_in_o,
  // internal sources
  input  wire logic [4:0]           general_output_bit_i,
  input  wire logic [15:0]          irq_i,
  input  wire logic                 clkrun_out_i,
  input  wire logic                 clkrun_oe_i,
  input  wire logic                 serialized_interrupt_out_i,
  input  wire logic                 serialized_interrupt_oe_i,
  input  wire logic                 legacy_dma_request_i,
  input  wire logic                 video_port_status_i,
  input  wire logic                 video_port_select_0_i,
  input  wire logic                 video_port_select_1_i,
  input  wire logic                 card_audio_pwm_i,
  input  wire logic                 low_power_state_flag_i,
  input  wire logic                 activity_led_1_i,
  input  wire logic                 activity_led_2_i,
  input  wire logic                 socket_activity_led_i,
  input  wire logic                 wake_event_output_i,
  input  wire logic                 ring_indicate_output_i,
  input  wire logic                 ring_indicate_en_i,
  input  wire logic                 pme_i,
  input  wire logic                 ring_wake_mux_select_i,
  // sampled terminal functions back to the device
  output logic      [4:0]           general_input_bit_o,
  output logic                      legacy_dma_grant_o,
  output logic                      pci_lock_o,
  output logic                      clkrun_in_o,
  output logic                      serialized_interrupt_in_o,
  // multipurpose terminals
  input  wire logic [MPTR_PINS-1:0] multipurpose_pin_i,
  output logic      [MPTR_PINS-1:0] multipurpose_pin_o,
  output logic      [MPTR_PINS-1:0] multipurpose_pin_oe_o,
  // shared ring indicate / wake terminal
  output logic                      ring_wake_pin_o
);

  // -------------------------------------------------------------------------
  // terminal input synchronisers
  // -------------------------------------------------------------------------

  logic [MPTR_PINS-1:0] pin_meta_q;
  logic [MPTR_PINS-1:0] pin_sync_q;
  logic                 latch_meta_q;
  logic                 latch_sync_q;
  logic                 serial_mode;

  // two stages per terminal and for the strap
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_q   <= '0;
      pin_sync_q   <= '0;
      latch_meta_q <= 1'b1;
      latch_sync_q <= 1'b1;
    end else begin
      pin_meta_q   <= multipurpose_pin_i;
      pin_sync_q   <= pin_meta_q;
      latch_meta_q <= latch_pin_i;
      latch_sync_q <= latch_meta_q;
    end
  end

  assign serial_mode = !latch_sync_q; // strap pulled low

  // -------------------------------------------------------------------------
  // routing register
  // -------------------------------------------------------------------------

  logic [31:0] route_q;
  logic        cfg_sel;
  logic [31:0] be_mask;

  // either function reaches the same register
  assign cfg_sel = (cfg_addr_i == MPTR_ROUTING_OFS)
                && (cfg_func_i == MPTR_FUNC_0 || cfg_func_i == MPTR_FUNC_1);
  assign be_mask = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}},
                    {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};

  // eeprom load takes priority over a config write in the same cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      route_q <= MPTR_ROUTING_RST;
    end else if (eeprom_load_i) begin
      route_q <= eeprom_data_i & MPTR_ROUTING_WMASK;
    end else if (cfg_wr_i && cfg_sel) begin
      route_q <= (route_q & ~(be_mask & MPTR_ROUTING_WMASK))
               | (cfg_wdata_i & be_mask & MPTR_ROUTING_WMASK);
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_rdata_o <= '0;
      cfg_hit_o   <= 1'b0;
    end else begin
      cfg_hit_o   <= (cfg_rd_i || cfg_wr_i) && cfg_sel;
      cfg_rdata_o <= (cfg_rd_i && cfg_sel)
                   ? (route_q & MPTR_ROUTING_WMASK) : '0;
    end
  end

  // -------------------------------------------------------------------------
  // per-terminal source tables
  // -------------------------------------------------------------------------

  logic [MPTR_FLD_W-1:0] sel  [MPTR_PINS];
  logic [MPTR_CODES-1:0] tval [MPTR_PINS];
  logic [MPTR_CODES-1:0] toe  [MPTR_PINS];

  // unlisted entries stay zero, so such codes leave the terminal undriven
  always_comb begin
    for (int p = 0; p < MPTR_PINS; p++) begin
      tval[p] = '0;
      toe[p]  = '0;
    end
    // parallel irq lines: code n carries irq n
    for (int k = 0; k < MPTR_CODES; k++) begin
      tval[6][k] = irq_i[k] & MPTR_IRQ_MASK_T6[k];
      toe[6][k]  = MPTR_IRQ_MASK_T6[k];
      tval[5][k] = irq_i[k] & MPTR_IRQ_MASK_T5[k];
      toe[5][k]  = MPTR_IRQ_MASK_T5[k];
      tval[4][k] = irq_i[k] & MPTR_IRQ_MASK_T4[k];
      toe[4][k]  = MPTR_IRQ_MASK_T4[k];
      tval[3][k] = irq_i[k] & MPTR_IRQ_MASK_T3[k];
      toe[3][k]  = MPTR_IRQ_MASK_T3[k];
      tval[2][k] = irq_i[k] & MPTR_IRQ_MASK_T2[k];
      toe[2][k]  = MPTR_IRQ_MASK_T2[k];
    end
    // terminal 6 clock run, two-way
    tval[6][MPTR_SEL_CLKRUN] = clkrun_out_i;
    toe[6][MPTR_SEL_CLKRUN]  = clkrun_oe_i;
    // terminal 5 functions
    tval[5][MPTR_SEL_GPO]    = general_output_bit_i[4];
    toe[5][MPTR_SEL_GPO]     = 1'b1;
    tval[5][MPTR_SEL_VSTAT]  = video_port_status_i;
    toe[5][MPTR_SEL_VSTAT]   = 1'b1;
    tval[5][MPTR_SEL_VSEL]   = video_port_select_1_i;
    toe[5][MPTR_SEL_VSEL]    = 1'b1;
    tval[5][MPTR_SEL_AUDIO]  = card_audio_pwm_i;
    toe[5][MPTR_SEL_AUDIO]   = 1'b1;
    tval[5][MPTR_SEL_D3_T5]  = low_power_state_flag_i;
    toe[5][MPTR_SEL_D3_T5]   = 1'b1;
    tval[5][MPTR_SEL_LED1]   = activity_led_1_i;
    toe[5][MPTR_SEL_LED1]    = 1'b1;
    tval[5][MPTR_SEL_SKTLED] = socket_activity_led_i;
    toe[5][MPTR_SEL_SKTLED]  = 1'b1;
    tval[5][MPTR_SEL_WAKE]   = wake_event_output_i;
    toe[5][MPTR_SEL_WAKE]    = 1'b1;
    // terminal 4 functions
    tval[4][MPTR_SEL_GPO]    = general_output_bit_i[3];
    toe[4][MPTR_SEL_GPO]     = 1'b1;
    tval[4][MPTR_SEL_VSTAT]  = video_port_status_i;
    toe[4][MPTR_SEL_VSTAT]   = 1'b1;
    tval[4][MPTR_SEL_AUDIO]  = card_audio_pwm_i;
    toe[4][MPTR_SEL_AUDIO]   = 1'b1;
    tval[4][MPTR_SEL_RING]   = ring_indicate_output_i;
    toe[4][MPTR_SEL_RING]    = 1'b1;
    tval[4][MPTR_SEL_SKTLED] = socket_activity_led_i;
    toe[4][MPTR_SEL_SKTLED]  = 1'b1;
    tval[4][MPTR_SEL_WAKE]   = wake_event_output_i;
    toe[4][MPTR_SEL_WAKE]    = 1'b1;
    // terminal 3 serialized interrupt, two-way
    tval[3][MPTR_SEL_SERIRQ] = serialized_interrupt_out_i;
    toe[3][MPTR_SEL_SERIRQ]  = serialized_interrupt_oe_i;
    // terminal 2 functions
    tval[2][MPTR_SEL_GPO]    = general_output_bit_i[2];
    toe[2][MPTR_SEL_GPO]     = 1'b1;
    tval[2][MPTR_SEL_DMA]    = legacy_dma_request_i;
    toe[2][MPTR_SEL_DMA]     = 1'b1;
    tval[2][MPTR_SEL_VSTAT]  = video_port_status_i;
    toe[2][MPTR_SEL_VSTAT]   = 1'b1;
    tval[2][MPTR_SEL_VSEL]   = video_port_select_0_i;
    toe[2][MPTR_SEL_VSEL]    = 1'b1;
    tval[2][MPTR_SEL_AUDIO]  = card_audio_pwm_i;
    toe[2][MPTR_SEL_AUDIO]   = 1'b1;
    tval[2][MPTR_SEL_D3_T2]  = low_power_state_flag_i;
    toe[2][MPTR_SEL_D3_T2]   = 1'b1;
    tval[2][MPTR_SEL_RING]   = ring_indicate_output_i;
    toe[2][MPTR_SEL_RING]    = 1'b1;
    tval[2][MPTR_SEL_LED2]   = activity_led_2_i;
    toe[2][MPTR_SEL_LED2]    = 1'b1;
    tval[2][MPTR_SEL_WAKE]   = wake_event_output_i;
    toe[2][MPTR_SEL_WAKE]    = 1'b1;
    tval[2][MPTR_SEL_IRQ7_T2] = irq_i[MPTR_IRQ7];
    toe[2][MPTR_SEL_IRQ7_T2]  = 1'b1;
    // terminals 1 and 0: input or output bit
    tval[1][MPTR_SEL_GPO]    = general_output_bit_i[1];
    toe[1][MPTR_SEL_GPO]     = 1'b1;
    tval[0][MPTR_SEL_GPO]    = general_output_bit_i[0];
    toe[0][MPTR_SEL_GPO]     = 1'b1;
  end

  // -------------------------------------------------------------------------
  // terminal drivers
  // -------------------------------------------------------------------------

  for (genvar p = 0; p < MPTR_PINS; p++) begin : g_pin
    assign sel[p] = route_q[p*MPTR_FLD_W +: MPTR_FLD_W];
    mptr_pin_mux u_mux (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .sel_i       (sel[p]),
      .src_val_i   (tval[p]),
      .src_oe_i    (toe[p]),
      .force_en_i  ((p == 4) && serial_mode),
      .force_val_i (1'b0),
      .force_oe_i  (scl_drive_low_i),
      .pin_o       (multipurpose_pin_o[p]),
      .pin_oe_o    (multipurpose_pin_oe_o[p])
    );
  end

  // shared ring indicate / wake terminal
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ring_wake_pin_o <= 1'b0;
    end else if (ring_wake_mux_select_i) begin
      ring_wake_pin_o <= pme_i;
    end else if (ring_indicate_en_i) begin
      ring_wake_pin_o <= ring_indicate_output_i;
    end else begin
      ring_wake_pin_o <= pme_i;
    end
  end

  // sampled functions, gated by their selection; scl_in_o by serial-bus mode
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      general_input_bit_o       <= '0;
      legacy_dma_grant_o        <= 1'b0;
      pci_lock_o                <= 1'b0;
      clkrun_in_o               <= 1'b0;
      serialized_interrupt_in_o <= 1'b0;
      scl_in_o                  <= 1'b0;
    end else begin
      general_input_bit_o[0] <= (sel[0] == MPTR_SEL_GPI) & pin_sync_q[0];
      general_input_bit_o[1] <= (sel[1] == MPTR_SEL_GPI) & pin_sync_q[1];
      general_input_bit_o[2] <= (sel[2] == MPTR_SEL_GPI) & pin_sync_q[2];
      general_input_bit_o[3] <= (sel[4] == MPTR_SEL_GPI) & pin_sync_q[4]
                              & !serial_mode;
      general_input_bit_o[4] <= (sel[5] == MPTR_SEL_GPI) & pin_sync_q[5];
      legacy_dma_grant_o     <= (sel[5] == MPTR_SEL_DMA) & pin_sync_q[5];
      pci_lock_o <= (sel[4] == MPTR_SEL_LOCK) & pin_sync_q[4] & !serial_mode;
      clkrun_in_o <= (sel[6] == MPTR_SEL_CLKRUN) & pin_sync_q[6];
      serialized_interrupt_in_o <= (sel[3] == MPTR_SEL_SERIRQ)
                                 & pin_sync_q[3];
      scl_in_o <= serial_mode & pin_sync_q[4];
    end
  end

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------

  logic seen_q;

  // marks the first clock after reset release
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_full_write;
    cfg_wr_i && cfg_sel && (cfg_be_i == 4'hF) && !eeprom_load_i;
  endsequence

  sequence s_wake_only;
    ring_wake_mux_select_i && ring_indicate_en_i;
  endsequence

  a_route_reset_val: assert property (
    !seen_q |-> route_q == MPTR_ROUTING_RST)
    else $error("routing register not at reset value");
  a_first_all_input: assert property (
    !seen_q |-> multipurpose_pin_oe_o == '0)
    else $error("terminal driven right after reset");
  a_upper_bits_zero: assert property (
    route_q[31:28] == 4'h0 && cfg_rdata_o[31:28] == 4'h0)
    else $error("upper routing bits not zero");
  a_eeprom_load: assert property (
    eeprom_load_i |=> route_q == ($past(eeprom_data_i) & MPTR_ROUTING_WMASK))
    else $error("eeprom load not taken");
  a_write_then_read: assert property (
    s_full_write ##1 (!cfg_wr_i && !eeprom_load_i)
    ##1 (cfg_rd_i && cfg_sel && !eeprom_load_i && !cfg_wr_i)
    |=> cfg_rdata_o == ($past(cfg_wdata_i, 3) & MPTR_ROUTING_WMASK))
    else $error("read back differs from write");
  a_gpo_drive: assert property (
    (sel[5] == MPTR_SEL_GPO) |=> multipurpose_pin_oe_o[5]
      && multipurpose_pin_o[5] == $past(general_output_bit_i[4]))
    else $error("output bit not driven on terminal 5");
  a_scl_override: assert property (
    serial_mode |=> multipurpose_pin_oe_o[4] == $past(scl_drive_low_i)
      && !multipurpose_pin_o[4])
    else $error("terminal 4 not carrying serial clock");
  a_rsvd_undriven: assert property (
    (sel[6] == MPTR_SEL_RSVD || sel[3] == MPTR_SEL_RSVD) |=>
      !(multipurpose_pin_oe_o[6] && $past(sel[6]) == MPTR_SEL_RSVD)
      && !(multipurpose_pin_oe_o[3] && $past(sel[3]) == MPTR_SEL_RSVD))
    else $error("reserved code drives a terminal");
  a_ring_priority: assert property (
    (!ring_wake_mux_select_i && ring_indicate_en_i)
    |=> ring_wake_pin_o == $past(ring_indicate_output_i))
    else $error("ring indicate lost on shared terminal");
  a_wake_only_mux: assert property (
    s_wake_only |=> ring_wake_pin_o == $past(pme_i))
    else $error("ring indicate leaked with mux bit set");

endmodule
